// ===== rtl/uhc_op_regs.sv
//------------------------------------------------------------------------------
// Purpose: Operational register bank of the second full/low-speed host function
// Assumes: Host driver uses aligned dword accesses in a 4-Kbyte window
// Notes:   Registers beyond control/status core sit in a plain word store
// Function
// [R1] Decode dword offsets 00h to 58h in the second function's window.
// [R2] Registers keep the same meaning and defaults as the first function's.
// [R3] Revision code in bits 7:0, bits 31:9 read zero.
// [R4] Bit 8 of revision follows legacy-enable pin, not writable.
// [R5] No legacy emulation registers here, yet legacy bit still reported.
// [R6] Control bits 1:0 set control-to-bulk service ratio 1:1 to 4:1.
// [R7] Control bit 2 enables periodic list from the next frame.
// [R8] Control bit 3 enables isochronous service from the next frame.
// [R9] Control bit 4 enables control list from the next frame.
// [R10] Control bit 5 enables bulk list from the next frame.
// [R11] Control bits 7:6 hold functional state, changed by software or controller.
// [R12] Functional state loads 00b on hardware, 11b on software reset.
// [R13] Control bit 8 routes event interrupts to management or normal output.
// [R14] Control bit 9 marks wakeup support, writable by software and controller.
// [R15] With bit 10 set, resume flag asserts power event output; else low.
// [R16] Routing and wakeup-support bits survive software reset, clear on hardware.
// [R17] Resume flag sets on bus resume, not on software entering resume.
//------------------------------------------------------------------------------
`timescale 1ns/100ps
`include "uhc_defines.svh"

module uhc_op_regs #(
  parameter logic [7:0] REV_CODE = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Memory-mapped register access
  input wire uhc_pkg::uhc_req_type MEM_REQ,
  output uhc_pkg::uhc_rsp_type MEM_RSP,
  // Pins
  input wire logic LEGACY_ENABLE_PIN,
  // Controller side events and updates
  input wire logic FRAME_START_IN,
  input wire logic RESUME_DETECT_IN,
  input wire logic [6:0] EVENT_SET_IN,
  input wire logic HC_STATE_SET,
  input wire uhc_pkg::uhc_fstate_type HC_STATE_VAL,
  input wire logic HC_WAKEUP_SET,
  input wire logic HC_WAKEUP_VAL,
  // Control toward the scheduler
  output uhc_pkg::uhc_ctrl_type CTRL_OUT,
  output logic [3:0] LIST_SERVICE,
  output logic SOFT_RESET_OUT,
  // Interrupt and power event outputs
  output logic MGMT_IRQ_OUT,
  output logic PCI_IRQ_OUT,
  output logic POWER_EVENT_OUT
);

  // Every assertion below runs on the system clock and sleeps during reset
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  //----------------------------------------------------------------------------
  // Decode helpers
  //----------------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `UHC_OFF_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic own_reg(input logic [11:0] a);
    own_reg = (a <= `UHC_OFF_MASK_CLR);
  endfunction

  logic acc_ok;
  logic wr_ok;
  logic rd_ok;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_evt;
  logic wr_mset;
  logic wr_mclr;
  logic sw_resume_wr;

  // Legal dword accesses only; others write nothing and read zero [R1]
  assign acc_ok = MEM_REQ.sel && mapped(MEM_REQ.addr);
  assign wr_ok = acc_ok && MEM_REQ.wr;
  assign rd_ok = acc_ok && !MEM_REQ.wr;
  assign wr_ctrl = wr_ok && hit(MEM_REQ.addr, `UHC_OFF_CONTROL);
  assign wr_cmd = wr_ok && hit(MEM_REQ.addr, `UHC_OFF_COMMAND);
  assign wr_evt = wr_ok && hit(MEM_REQ.addr, `UHC_OFF_EVENTS);
  assign wr_mset = wr_ok && hit(MEM_REQ.addr, `UHC_OFF_MASK_SET);
  assign wr_mclr = wr_ok && hit(MEM_REQ.addr, `UHC_OFF_MASK_CLR);
  // Software moving the state into resume must not look like bus resume
  assign sw_resume_wr = wr_ctrl &&
    (MEM_REQ.wdata[7:6] == 2'(uhc_pkg::state_resume)); // [R17]

  //----------------------------------------------------------------------------
  // Legacy pin synchroniser
  //----------------------------------------------------------------------------
  logic leg_s1_q;
  logic leg_s2_q;
  logic leg_s3_q;
  logic legacy_q;
  logic legacy_d;

  // Value is taken only once the last two stages agree
  always_comb begin
    legacy_d = legacy_q;
    if (leg_s2_q == leg_s3_q) begin
      legacy_d = leg_s3_q; // [R4]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      leg_s1_q <= 1'b0;
      leg_s2_q <= 1'b0;
      leg_s3_q <= 1'b0;
      legacy_q <= 1'b0;
    end else begin
      leg_s1_q <= LEGACY_ENABLE_PIN;
      leg_s2_q <= leg_s1_q;
      leg_s3_q <= leg_s2_q;
      legacy_q <= legacy_d;
    end
  end

  //----------------------------------------------------------------------------
  // Software reset request
  //----------------------------------------------------------------------------
  logic hcr_q;
  logic hcr_d;
  logic [2:0] cmd_q;
  logic [2:0] cmd_d;

  // Request lives one cycle; it clears itself in the cycle the reset is applied
  always_comb begin
    hcr_d = !hcr_q && wr_cmd && MEM_REQ.wdata[`UHC_CMD_RESET_BIT];
    cmd_d = cmd_q;
    if (hcr_q) begin
      cmd_d = 3'h0;
    end else if (wr_cmd) begin
      cmd_d = MEM_REQ.wdata[3:1];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hcr_q <= 1'b0;
      cmd_q <= 3'h0;
    end else begin
      hcr_q <= hcr_d;
      cmd_q <= cmd_d;
    end
  end

  //----------------------------------------------------------------------------
  // Control register
  //----------------------------------------------------------------------------
  uhc_pkg::uhc_ctrl_type ctrl_q;
  uhc_pkg::uhc_ctrl_type ctrl_d;

  // Software reset beats any write in the same cycle
  always_comb begin
    ctrl_d = ctrl_q;
    if (hcr_q) begin
      ctrl_d = uhc_pkg::uhc_ctrl_type'(`UHC_CTRL_HW_RESET);
      ctrl_d.functional_state = uhc_pkg::uhc_fstate_type'(`UHC_STATE_SW_RESET); // [R12]
      ctrl_d.irq_route_select = ctrl_q.irq_route_select; // [R16]
      ctrl_d.wakeup_supported = ctrl_q.wakeup_supported; // [R16]
    end else begin
      if (wr_ctrl) begin
        ctrl_d = uhc_pkg::uhc_ctrl_type'(MEM_REQ.wdata[`UHC_CTRL_WIDTH-1:0]); // [R6] [R13] [R14] [R15]
      end
      // Controller updates win over a software write in the same cycle
      if (HC_STATE_SET) begin
        ctrl_d.functional_state = HC_STATE_VAL; // [R11]
      end
      if (HC_WAKEUP_SET) begin
        ctrl_d.wakeup_supported = HC_WAKEUP_VAL; // [R14]
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= uhc_pkg::uhc_ctrl_type'(`UHC_CTRL_HW_RESET); // [R12] [R16]
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  //----------------------------------------------------------------------------
  // List service enables, sampled at frame start
  //----------------------------------------------------------------------------
  logic [3:0] list_q;
  logic [3:0] list_d;

  // A change mid-frame must not disturb the frame in progress
  always_comb begin
    list_d = list_q;
    if (hcr_q) begin
      list_d = 4'h0;
    end else if (FRAME_START_IN) begin
      list_d = {ctrl_q.bulk_list_on, ctrl_q.ctrl_list_on,
                ctrl_q.iso_service_on, ctrl_q.periodic_list_on}; // [R7] [R8] [R9] [R10]
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      list_q <= 4'h0;
    end else begin
      list_q <= list_d;
    end
  end

  //----------------------------------------------------------------------------
  // Event flags and mask
  //----------------------------------------------------------------------------
  logic [6:0] evt_q;
  logic [6:0] evt_d;
  logic [6:0] evt_set;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] mask_w;
  logic irq_any;

  assign mask_w = {MEM_REQ.wdata[`UHC_MASK_MASTER_BIT], MEM_REQ.wdata[6:0]};

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    evt_set = EVENT_SET_IN;
    evt_set[`UHC_EVT_RESUME_BIT] = RESUME_DETECT_IN && !sw_resume_wr; // [R17]
    evt_d = evt_q;
    mask_d = mask_q;
    if (hcr_q) begin
      evt_d = `UHC_EVT_RESET;
      mask_d = `UHC_MASK_RESET;
    end else begin
      if (wr_evt) begin
        evt_d = evt_q & ~MEM_REQ.wdata[6:0];
      end
      evt_d = evt_d | evt_set;
      if (wr_mset) begin
        mask_d = mask_q | mask_w;
      end else if (wr_mclr) begin
        mask_d = mask_q & ~mask_w;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      evt_q <= `UHC_EVT_RESET;
      mask_q <= `UHC_MASK_RESET;
    end else begin
      evt_q <= evt_d;
      mask_q <= mask_d;
    end
  end

  // Unmasked event goes to exactly one output
  assign irq_any = mask_q[7] && |(evt_q & mask_q[6:0]);
  assign MGMT_IRQ_OUT = irq_any && ctrl_q.irq_route_select; // [R13]
  assign PCI_IRQ_OUT = irq_any && !ctrl_q.irq_route_select; // [R13]
  // Level while the resume flag stands; gated by the wake enable
  assign POWER_EVENT_OUT = ctrl_q.wakeup_event_on && evt_q[`UHC_EVT_RESUME_BIT]; // [R15]

  //----------------------------------------------------------------------------
  // Word store for the remaining registers
  //----------------------------------------------------------------------------
  logic [31:0] store_rdata;

  // Same meaning and defaults as the first function: plain words [R2]
  uhc_store #(
    .AW(5),
    .DW(32)
  ) u_store (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .wr_en(wr_ok && !own_reg(MEM_REQ.addr)),
    .addr(MEM_REQ.addr[6:2]),
    .wdata(MEM_REQ.wdata),
    .rdata(store_rdata)
  );

  //----------------------------------------------------------------------------
  // Read answer
  //----------------------------------------------------------------------------
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic rv_q;
  logic rv_d;
  logic from_store_q;
  logic from_store_d;

  // Own registers are muxed here; the store answers from its own flop
  always_comb begin
    rd_d = 32'h0000_0000;
    rv_d = MEM_REQ.sel && !MEM_REQ.wr;
    from_store_d = rd_ok && !own_reg(MEM_REQ.addr);
    if (rd_ok) begin
      if (hit(MEM_REQ.addr, `UHC_OFF_REVISION)) begin
        rd_d[7:0] = REV_CODE; // [R3]
        rd_d[`UHC_REV_LEGACY_BIT] = legacy_q; // [R4] [R5]
      end else if (hit(MEM_REQ.addr, `UHC_OFF_CONTROL)) begin
        rd_d[`UHC_CTRL_WIDTH-1:0] = ctrl_q;
      end else if (hit(MEM_REQ.addr, `UHC_OFF_COMMAND)) begin
        rd_d[3:0] = {cmd_q, hcr_q};
      end else if (hit(MEM_REQ.addr, `UHC_OFF_EVENTS)) begin
        rd_d[6:0] = evt_q;
      end else if (own_reg(MEM_REQ.addr)) begin
        rd_d[6:0] = mask_q[6:0];
        rd_d[`UHC_MASK_MASTER_BIT] = mask_q[7];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_q <= 32'h0000_0000;
      rv_q <= 1'b0;
      from_store_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      rv_q <= rv_d;
      from_store_q <= from_store_d;
    end
  end

  // One driver for the whole answer; both halves come from flops
  assign MEM_RSP = {rv_q, (from_store_q ? store_rdata : rd_q)}; // [R1]
  assign CTRL_OUT = ctrl_q;
  assign LIST_SERVICE = list_q;
  assign SOFT_RESET_OUT = hcr_q;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  logic rd_rev;
  logic rd_bad;
  assign rd_rev = rd_ok && hit(MEM_REQ.addr, `UHC_OFF_REVISION);
  assign rd_bad = MEM_REQ.sel && !MEM_REQ.wr && !mapped(MEM_REQ.addr);

  a_unmapped_read_zero: assert property (rd_bad |=> MEM_RSP.valid && MEM_RSP.data == 32'h0000_0000) // [R1]
    else $error("unmapped read not zero");
  a_rev_code_layout: assert property (rd_rev |=> MEM_RSP.data[31:9] == 23'h0 && MEM_RSP.data[7:0] == REV_CODE) // [R3]
    else $error("revision layout wrong");
  a_legacy_pin_follow: assert property (LEGACY_ENABLE_PIN [*5] |=> MEM_RSP.data[8] || !$past(rd_rev)) // [R4]
    else $error("legacy bit not following pin");
  a_ratio_write_store: assert property (wr_ctrl && !hcr_q |=> ctrl_q.ctrl_bulk_ratio == $past(MEM_REQ.wdata[1:0])) // [R6]
    else $error("ratio not stored");
  a_list_frame_hold: assert property (!FRAME_START_IN && !hcr_q |=> $stable(LIST_SERVICE)) // [R7] [R8] [R9] [R10]
    else $error("list enables changed mid-frame");
  a_list_frame_take: assert property (FRAME_START_IN && !hcr_q |=>
    LIST_SERVICE == $past({ctrl_q.bulk_list_on, ctrl_q.ctrl_list_on, ctrl_q.iso_service_on,
    ctrl_q.periodic_list_on})) // [R7] [R8] [R9] [R10]
    else $error("list enables not taken at frame start");
  a_hc_state_set: assert property (HC_STATE_SET && !hcr_q |=> ctrl_q.functional_state == $past(HC_STATE_VAL)) // [R11]
    else $error("controller state update lost");
  a_soft_reset_state: assert property (wr_cmd && MEM_REQ.wdata[0] && !hcr_q |=> hcr_q ##1
    (ctrl_q.functional_state == uhc_pkg::state_suspended && !hcr_q)) // [R12]
    else $error("software reset state wrong");
  a_soft_reset_keep: assert property (hcr_q |=> $stable(ctrl_q.irq_route_select) && $stable(ctrl_q.wakeup_supported)) // [R16]
    else $error("route or wakeup bit lost on software reset");
  a_route_one_output: assert property (irq_any |-> (MGMT_IRQ_OUT == ctrl_q.irq_route_select) &&
    (PCI_IRQ_OUT != ctrl_q.irq_route_select)) // [R13]
    else $error("interrupt routed wrongly");
  a_wake_gate_off: assert property (!ctrl_q.wakeup_event_on |-> !POWER_EVENT_OUT) // [R15]
    else $error("power event without enable");
  a_wake_event_on: assert property (RESUME_DETECT_IN && !sw_resume_wr && !hcr_q && ctrl_q.wakeup_event_on
    && !wr_ctrl |=> POWER_EVENT_OUT) // [R15] [R17]
    else $error("power event missing after resume");
  a_sw_resume_quiet: assert property (sw_resume_wr && !evt_q[3] && !hcr_q && !EVENT_SET_IN[3] |=> !evt_q[3]) // [R17]
    else $error("resume flag set by software state write");

  c_soft_reset: cover property (hcr_q ##1 ctrl_q.functional_state == uhc_pkg::state_suspended);
  c_mgmt_irq: cover property (MGMT_IRQ_OUT);
  c_power_event: cover property (POWER_EVENT_OUT);
  c_frame_take: cover property (FRAME_START_IN ##1 LIST_SERVICE != 4'h0);

endmodule // uhc_op_regs

// ===== common/uhc_defines.svh
//------------------------------------------------------------------------------
// Purpose: Offsets, field positions, reset values of the second host function
// Assumes: Dword accesses only, 4-Kbyte window, byte addresses below
// Notes:   Included by bare name; definitions only
//------------------------------------------------------------------------------
`ifndef UHC_DEFINES_SVH
`define UHC_DEFINES_SVH

//------------------------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------------------------
`define UHC_OFF_REVISION 12'h000
`define UHC_OFF_CONTROL 12'h004
`define UHC_OFF_COMMAND 12'h008
`define UHC_OFF_EVENTS 12'h00C
`define UHC_OFF_MASK_SET 12'h010
`define UHC_OFF_MASK_CLR 12'h014
`define UHC_OFF_COMM_AREA 12'h018
`define UHC_OFF_PERIODIC_CUR 12'h01C
`define UHC_OFF_CTRL_HEAD 12'h020
`define UHC_OFF_CTRL_CUR 12'h024
`define UHC_OFF_BULK_HEAD 12'h028
`define UHC_OFF_BULK_CUR 12'h02C
`define UHC_OFF_DONE_HEAD 12'h030
`define UHC_OFF_FRAME_INTV 12'h034
`define UHC_OFF_FRAME_LEFT 12'h038
`define UHC_OFF_FRAME_NUM 12'h03C
`define UHC_OFF_PERIODIC_ST 12'h040
`define UHC_OFF_LS_THRESH 12'h044
`define UHC_OFF_HUB_DESC_A 12'h048
`define UHC_OFF_HUB_DESC_B 12'h04C
`define UHC_OFF_HUB_STATE 12'h050
`define UHC_OFF_PORT1 12'h054
`define UHC_OFF_PORT2 12'h058
`define UHC_OFF_LAST 12'h058

//------------------------------------------------------------------------------
// Field positions and widths
//------------------------------------------------------------------------------
`define UHC_REV_LEGACY_BIT 8
`define UHC_CTRL_WIDTH 11
`define UHC_CMD_RESET_BIT 0
`define UHC_EVT_WIDTH 7
`define UHC_EVT_RESUME_BIT 3
`define UHC_MASK_MASTER_BIT 31

//------------------------------------------------------------------------------
// Reset values
//------------------------------------------------------------------------------
`define UHC_CTRL_HW_RESET 11'h000
`define UHC_STATE_SW_RESET 2'h3
`define UHC_EVT_RESET 7'h00
`define UHC_MASK_RESET 8'h00
`define UHC_CMD_RESET 4'h0

`endif

// ===== common/uhc_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Types shared by the operational register bank
// Assumes: Field order of the control type matches register bits 10:0
// Notes:   Constants live in uhc_defines.svh
//------------------------------------------------------------------------------
package uhc_pkg;

  // Functional state, codes 0..3 in declaration order
  typedef enum logic [1:0] {
    state_reset,
    state_resume,
    state_running,
    state_suspended
  } uhc_fstate_type;

  // Control register bits 10:0, MSB first
  typedef struct packed {
    logic wakeup_event_on;
    logic wakeup_supported;
    logic irq_route_select;
    uhc_fstate_type functional_state;
    logic bulk_list_on;
    logic ctrl_list_on;
    logic iso_service_on;
    logic periodic_list_on;
    logic [1:0] ctrl_bulk_ratio;
  } uhc_ctrl_type;

  // Memory-mapped dword request
  typedef struct packed {
    logic sel;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } uhc_req_type;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } uhc_rsp_type;

endpackage

// ===== rtl/uhc_store.sv
//------------------------------------------------------------------------------
// Purpose: Word store for the registers kept outside the control core
// Assumes: One write or read per cycle, read data one cycle later
// Notes:   Words clear on reset so reads are never unknown
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module uhc_store #(
  parameter int AW = 5,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  // Read side
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] mem_d [2**AW];
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  //----------------------------------------------------------------------------
  // Next values
  //----------------------------------------------------------------------------
  always_comb begin
    mem_d = mem_q;
    if (wr_en) begin
      mem_d[addr] = wdata;
    end
    // Old word is read when write and read hit the same cycle
    rdata_d = mem_q[addr];
  end

  //----------------------------------------------------------------------------
  // Storage
  //----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
      rdata_q <= '0;
    end else begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule // uhc_store

// ===== sim/uhc_host_model.sv
//------------------------------------------------------------------------------
// Purpose: Host driver model issuing dword accesses to the register bank
// Assumes: Calls start 1 ns after a rising edge
// Notes:   A released bus shows inverted address and data, never the old word
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module uhc_host_model (
  // Clock
  input wire logic SYS_CLK,
  // Register access
  output uhc_pkg::uhc_req_type MEM_REQ,
  input wire uhc_pkg::uhc_rsp_type MEM_RSP
);
  // Idle bus from time zero
  initial MEM_REQ = '0;

  // Any dword address, aligned or not; idle cycle after, so no two drives share a step
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    MEM_REQ <= '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(posedge SYS_CLK);
    #1;
    q = (MEM_RSP.valid === 1'b1) ? MEM_RSP.data : 32'hXXXXXXXX;
    MEM_REQ <= '{sel: 1'b0, wr: ~w, addr: ~a, wdata: ~d};
    @(posedge SYS_CLK);
    #1;
  endtask
endmodule // uhc_host_model

// ===== sim/tb_uhc_op_regs.sv
//------------------------------------------------------------------------------
// Purpose: Self-checking bench of the operational register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Revision code is set by the bench, value arbitrary
//------------------------------------------------------------------------------
`timescale 1ns/100ps
`include "uhc_defines.svh"

module tb_uhc_op_regs;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  logic sys_clk = 1'b0, rst_b = 1'b0, legacy_pin = 1'b0, frame_start = 1'b0, resume_in = 1'b0;
  logic [6:0] event_set = 7'h00;
  logic hc_state_set = 1'b0, hc_wake_set = 1'b0, hc_wake_val = 1'b0;
  uhc_pkg::uhc_fstate_type hc_state_val = uhc_pkg::state_reset;
  uhc_pkg::uhc_req_type mem_req;
  uhc_pkg::uhc_rsp_type mem_rsp;
  uhc_pkg::uhc_ctrl_type ctrl_out;
  logic [3:0] list_service;
  logic [3:0] exp_ls = 4'h0;
  logic soft_reset, mgmt_irq, pci_irq, power_event;
  logic [31:0] rd_q;
  int num_errors = 0, comparisons = 0;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  uhc_host_model host (.SYS_CLK(sys_clk), .MEM_REQ(mem_req), .MEM_RSP(mem_rsp));

  uhc_op_regs #(.REV_CODE(REV)) dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .MEM_REQ(mem_req), .MEM_RSP(mem_rsp),
    .LEGACY_ENABLE_PIN(legacy_pin), .FRAME_START_IN(frame_start), .RESUME_DETECT_IN(resume_in),
    .EVENT_SET_IN(event_set), .HC_STATE_SET(hc_state_set), .HC_STATE_VAL(hc_state_val),
    .HC_WAKEUP_SET(hc_wake_set), .HC_WAKEUP_VAL(hc_wake_val), .CTRL_OUT(ctrl_out),
    .LIST_SERVICE(list_service), .SOFT_RESET_OUT(soft_reset), .MGMT_IRQ_OUT(mgmt_irq),
    .PCI_IRQ_OUT(pci_irq), .POWER_EVENT_OUT(power_event)
  );

  //----------------------------------------------------------------------------
  // Access and compare tasks
  //----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.access(1'b1, a, d, rd_q);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    host.access(1'b0, a, 32'h00000000, rd_q);
    chk($sformatf("reg %h", a), exp, rd_q);
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 200 cycles the tests need
  initial begin
    #400000;
    num_errors++;
    close_out();
  end

  //----------------------------------------------------------------------------
  // Test sequence
  //----------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    tick();
    // Defaults and revision word
    rchk(`UHC_OFF_CONTROL, 32'h00000000);
    rchk(`UHC_OFF_EVENTS, 32'h00000000);
    rchk(`UHC_OFF_REVISION, {24'h000000, REV});
    legacy_pin = 1'b1;
    repeat (4) tick();
    wr(`UHC_OFF_REVISION, 32'h00000000);
    rchk(`UHC_OFF_REVISION, {23'h000000, 1'b1, REV});
    legacy_pin = 1'b0;
    repeat (4) tick();
    rchk(`UHC_OFF_REVISION, {24'h000000, REV});
    // Storage words, then unmapped and misaligned places
    for (logic [11:0] a = 12'h018; a <= 12'h058; a += 12'h004) wr(a, {20'hA5C3E, a});
    for (logic [11:0] a = 12'h018; a <= 12'h058; a += 12'h004) rchk(a, {20'hA5C3E, a});
    wr(12'h05C, 32'hFFFFFFFF);
    rchk(12'h05C, 32'h00000000);
    wr(12'h005, 32'hFFFFFFFF);
    rchk(`UHC_OFF_CONTROL, 32'h00000000);
    // Control fields
    wr(`UHC_OFF_CONTROL, 32'hFFFFFFFF);
    rchk(`UHC_OFF_CONTROL, 32'h000007FF);
    for (int r = 0; r < 4; r++) begin
      wr(`UHC_OFF_CONTROL, {30'h00000000, r[1:0]});
      chk("ratio", r, ctrl_out.ctrl_bulk_ratio);
    end
    // List enables take effect only at a frame start
    for (int i = 0; i < 4; i++) begin
      wr(`UHC_OFF_CONTROL, 32'h00000004 << i);
      chk("list hold", exp_ls, list_service);
      frame_start = 1'b1;
      tick();
      frame_start = 1'b0;
      exp_ls = 4'h1 << i;
      chk("list", exp_ls, list_service);
    end
    // Controller side updates
    for (int s = 0; s < 4; s++) begin
      hc_state_val = uhc_pkg::uhc_fstate_type'(s[1:0]);
      hc_state_set = 1'b1;
      tick();
      hc_state_set = 1'b0;
      chk("state", s, ctrl_out.functional_state);
    end
    hc_wake_val = 1'b1;
    hc_wake_set = 1'b1;
    tick();
    hc_wake_set = 1'b0;
    chk("wake support", 32'h00000001, ctrl_out.wakeup_supported);
    wr(`UHC_OFF_COMMAND, 32'h0000000E);
    rchk(`UHC_OFF_COMMAND, 32'h0000000E);
    // Software reset keeps routing and wakeup support
    wr(`UHC_OFF_CONTROL, 32'h000007BF);
    fork
      wr(`UHC_OFF_COMMAND, 32'h00000001);
      begin
        tick();
        chk("soft reset", 32'h00000001, soft_reset);
      end
    join
    rchk(`UHC_OFF_CONTROL, 32'h000003C0);
    // Hardware reset clears them
    rst_b = 1'b0;
    repeat (2) tick();
    rst_b = 1'b1;
    tick();
    rchk(`UHC_OFF_CONTROL, 32'h00000000);
    // Interrupt routing
    wr(`UHC_OFF_MASK_SET, 32'h80000004);
    event_set = 7'h04;
    tick();
    event_set = 7'h00;
    chk("pci irq", 32'h00000001, pci_irq);
    chk("mgmt irq", 32'h00000000, mgmt_irq);
    wr(`UHC_OFF_CONTROL, 32'h00000100);
    chk("mgmt irq", 32'h00000001, mgmt_irq);
    chk("pci irq", 32'h00000000, pci_irq);
    wr(`UHC_OFF_EVENTS, 32'h00000004);
    chk("mgmt irq", 32'h00000000, mgmt_irq);
    // Clearing the master mask bit silences both outputs
    rchk(`UHC_OFF_MASK_CLR, 32'h80000004);
    wr(`UHC_OFF_MASK_CLR, 32'h80000000);
    event_set = 7'h04;
    tick();
    event_set = 7'h00;
    chk("mgmt irq", 32'h00000000, mgmt_irq);
    chk("pci irq", 32'h00000000, pci_irq);
    rchk(`UHC_OFF_EVENTS, 32'h00000004);
    wr(`UHC_OFF_EVENTS, 32'h00000004);
    // Bus resume with and without wake event enable
    resume_in = 1'b1;
    tick();
    resume_in = 1'b0;
    chk("power event", 32'h00000000, power_event);
    rchk(`UHC_OFF_EVENTS, 32'h00000008);
    wr(`UHC_OFF_EVENTS, 32'h00000008);
    wr(`UHC_OFF_CONTROL, 32'h00000400);
    resume_in = 1'b1;
    tick();
    resume_in = 1'b0;
    chk("power event", 32'h00000001, power_event);
    wr(`UHC_OFF_EVENTS, 32'h00000008);
    chk("power event", 32'h00000000, power_event);
    // Software entering resume in the same cycle sets no flag
    fork
      wr(`UHC_OFF_CONTROL, 32'h00000440);
      begin
        resume_in = 1'b1;
        tick();
        resume_in = 1'b0;
      end
    join
    chk("power event", 32'h00000000, power_event);
    rchk(`UHC_OFF_EVENTS, 32'h00000000);
    close_out();
  end
endmodule // tb_uhc_op_regs
